// ==== rtl/clar_pkg.sv ====
// Package with register map, field layout and types for the calendar alarm block
package clar_pkg;
    localparam logic [11:0] OFS_FLAG = 12'h000;
    localparam logic [11:0] OFS_ENAB = 12'h004;
    localparam logic [11:0] OFS_ALCFG = 12'h008;
    localparam logic [11:0] OFS_YEAR = 12'h00C;
    localparam logic [11:0] OFS_MONTH_DAY_VALUE = 12'h010;
    localparam logic [11:0] OFS_CTRL = 12'h014;
    localparam logic [11:0] OFS_EVSTAT = 12'h018;
    localparam logic [11:0] OFS_EVCLR = 12'h01C;
    localparam logic [11:0] OFS_EVEN = 12'h020;
    localparam int IRQ_BIT = 14;
    localparam int AL_EN_BIT = 15;
    localparam int AL_CHIME_BIT = 14;
    localparam logic [15:0] FLAG_MASK = 16'h4000;
    localparam logic [15:0] YEAR_MASK = 16'h00FF;
    localparam logic [15:0] MONTH_DAY_VALUE_MASK = 16'h1F3F;
    localparam logic [15:0] REG16_RST = 16'h0000;
    localparam logic [7:0] RPT_ZERO = 8'h00;
    localparam logic [7:0] RPT_ONE = 8'h01;
    localparam logic [1:0] PTR_ONE = 2'h1;
    localparam logic [3:0] MASK_RSV_A = 4'hA;
    localparam logic [2:0] EV_RST = 3'h0;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    typedef struct packed {
        logic enable;
        logic chime;
        logic [3:0] interval_mask;
        logic [1:0] value_pointer;
        logic [7:0] repeat_count;
    } clar_alcfg_type;
    typedef struct packed {
        logic [3:0] year_tens_digit;
        logic [3:0] year_ones_digit;
    } clar_year_type;
    typedef struct packed {
        logic month_tens_digit;
        logic [3:0] month_ones_digit;
        logic [1:0] day_tens_digit;
        logic [3:0] day_ones_digit;
    } clar_month_day_value_type;
endpackage

// ==== rtl/clar_sticky.sv ====
// Sticky event bit with set-wins-over-clear
`timescale 1ns/1ps
`default_nettype none
module clar_sticky (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic set_pulse,
    input wire logic clr_pulse,
    output logic bit_q
);
    logic bit_reg;
    logic bit_next;
    // Set wins so a coincident event is never lost
    assign bit_next = set_pulse | (bit_reg & ~clr_pulse);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bit_reg <= 1'b0;
        end else begin
            bit_reg <= bit_next;
        end
    end
    assign bit_q = bit_reg;
endmodule // clar_sticky
`default_nettype wire

// ==== rtl/clar_regs.sv ====
// Calendar alarm configuration, date registers and interrupt flag over APB
`timescale 1ns/1ps
`default_nettype none
module clar_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic alarm_event,
    input wire logic alarm_value_access,
    output logic [3:0] alarm_interval_mask,
    output logic [1:0] alarm_value_pointer,
    output logic alarm_enable,
    output logic clock_irq,
    output logic irq
);
    clar_pkg::clar_alcfg_type alcfg_reg, alcfg_next;
    clar_pkg::clar_year_type year_reg;
    clar_pkg::clar_month_day_value_type month_day_value_reg;
    logic flag_reg, flag_next;
    logic ie_reg;
    logic unlock_reg;
    logic [2:0] even_reg;
    logic [2:0] evstat;
    logic [31:0] prdata_reg;
    logic wr_go, rd_go;
    logic sel_flag, sel_enab, sel_alcfg, sel_year, sel_month_day_value;
    logic sel_ctrl, sel_evstat, sel_evclr, sel_even, mapped;
    logic [15:0] rd_mux;
    logic [15:0] alcfg_word;
    logic clock_event;
    logic rpt_zero, mask_rsv;
    logic [2:0] ev_set;
    logic wr_alcfg;
    logic wr_flag;
    logic wr_enab;
    logic wr_ctrl;
    logic wr_even;
    logic wr_year;
    logic wr_month_day_value;
    logic wr_evclr;
    logic rd_setup;

    assign pready = 1'b1;
    assign wr_go = psel & penable & pwrite;
    assign rd_go = psel & penable & ~pwrite;
    assign sel_flag = paddr == clar_pkg::OFS_FLAG;
    assign sel_enab = paddr == clar_pkg::OFS_ENAB;
    assign sel_alcfg = paddr == clar_pkg::OFS_ALCFG;
    assign sel_year = paddr == clar_pkg::OFS_YEAR;
    assign sel_month_day_value = paddr == clar_pkg::OFS_MONTH_DAY_VALUE;
    assign sel_ctrl = paddr == clar_pkg::OFS_CTRL;
    assign sel_evstat = paddr == clar_pkg::OFS_EVSTAT;
    assign sel_evclr = paddr == clar_pkg::OFS_EVCLR;
    assign sel_even = paddr == clar_pkg::OFS_EVEN;
    assign mapped = sel_flag | sel_enab | sel_alcfg | sel_year | sel_month_day_value
        | sel_ctrl | sel_evstat | sel_evclr | sel_even;
    // Unmapped addresses answer with an error and no effect
    assign pslverr = psel & penable & ~mapped;

    // Named write strobes keep the checks below readable
    assign wr_alcfg = wr_go & sel_alcfg;
    assign wr_flag = wr_go & sel_flag;
    assign wr_enab = wr_go & sel_enab;
    assign wr_ctrl = wr_go & sel_ctrl;
    assign wr_even = wr_go & sel_even;
    // Locked calendar writes vanish silently, no bus error
    assign wr_year = wr_go & sel_year & unlock_reg;
    assign wr_month_day_value = wr_go & sel_month_day_value & unlock_reg;
    assign wr_evclr = wr_go & sel_evclr;
    assign rd_setup = psel & ~penable & ~pwrite;

    assign rpt_zero = alcfg_reg.repeat_count == clar_pkg::RPT_ZERO;
    // An alarm event is a clock interrupt source only while the alarm is enabled
    assign clock_event = alarm_event & alcfg_reg.enable;
    // Reserved interval codes are flagged, the stored value is kept
    assign mask_rsv = (alcfg_reg.interval_mask >= clar_pkg::MASK_RSV_A);

    always_comb begin
        alcfg_next = alcfg_reg;
        if (wr_go && sel_alcfg) begin
            alcfg_next = clar_pkg::clar_alcfg_type'(pwdata[15:0]);
        end else begin
            if (alarm_value_access) begin
                alcfg_next.value_pointer = alcfg_reg.value_pointer
                    - clar_pkg::PTR_ONE;
            end
            if (clock_event) begin
                if (!rpt_zero || alcfg_reg.chime) begin
                    alcfg_next.repeat_count = alcfg_reg.repeat_count
                        - clar_pkg::RPT_ONE;
                end
                if (rpt_zero && !alcfg_reg.chime) begin
                    alcfg_next.enable = 1'b0;
                end
            end
        end
    end

    // Hardware set wins over a software write of zero
    assign flag_next = clock_event
        | ((wr_go && sel_flag) ? pwdata[clar_pkg::IRQ_BIT] : flag_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alcfg_reg <= clar_pkg::clar_alcfg_type'(clar_pkg::REG16_RST);
            flag_reg <= 1'b0;
        end else begin
            alcfg_reg <= alcfg_next;
            flag_reg <= flag_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_reg <= 1'b0;
            unlock_reg <= 1'b0;
            even_reg <= clar_pkg::EV_RST;
        end else if (wr_go) begin
            if (sel_enab) ie_reg <= pwdata[clar_pkg::IRQ_BIT];
            if (sel_ctrl) unlock_reg <= pwdata[0];
            if (sel_even) even_reg <= pwdata[2:0];
        end
    end

    // Calendar values have no defined reset, but clear them for determinism
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            year_reg <= '0;
            month_day_value_reg <= '0;
        end else if (wr_go && unlock_reg) begin
            if (sel_year) year_reg <= pwdata[7:0];
            if (sel_month_day_value) month_day_value_reg <= {pwdata[12:8], pwdata[5:0]};
        end
    end

    // Sticky events: clock interrupt, alarm disabled itself, reserved mask
    assign ev_set[0] = clock_event;
    assign ev_set[1] = clock_event & rpt_zero & ~alcfg_reg.chime;
    assign ev_set[2] = mask_rsv;
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_ev
            clar_sticky u_ev (
                .pclk(pclk),
                .presetn(presetn),
                .set_pulse(ev_set[gi]),
                .clr_pulse(wr_go & sel_evclr & pwdata[gi]),
                .bit_q(evstat[gi])
            );
        end
    endgenerate

    assign alcfg_word = alcfg_reg;
    assign rd_mux =
        sel_flag ? (16'(flag_reg) << clar_pkg::IRQ_BIT) :
        sel_enab ? (16'(ie_reg) << clar_pkg::IRQ_BIT) :
        sel_alcfg ? alcfg_word :
        sel_year ? (16'(year_reg) & clar_pkg::YEAR_MASK) :
        sel_month_day_value ? ({3'h0, month_day_value_reg[10:6], 2'h0, month_day_value_reg[5:0]}
            & clar_pkg::MONTH_DAY_VALUE_MASK) :
        sel_ctrl ? 16'(unlock_reg) :
        sel_evstat ? 16'(evstat) :
        sel_even ? 16'(even_reg) : clar_pkg::REG16_RST;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= clar_pkg::RDATA_ZERO;
        end else if (psel && !penable && !pwrite) begin
            prdata_reg <= {16'h0000, rd_mux};
        end
    end
    assign prdata = prdata_reg;

    assign alarm_interval_mask = alcfg_reg.interval_mask;
    assign alarm_value_pointer = alcfg_reg.value_pointer;
    assign alarm_enable = alcfg_reg.enable;
    assign clock_irq = flag_reg & ie_reg;
    assign irq = |(evstat & even_reg);

    a_auto_disable: assert property (@(posedge pclk) disable iff (!presetn)
        clock_event && rpt_zero && !alcfg_reg.chime && !(wr_go && sel_alcfg)
        |=> !alarm_enable) else $error("alarm not disabled");
    a_rpt_decr: assert property (@(posedge pclk) disable iff (!presetn)
        clock_event && !rpt_zero && !(wr_go && sel_alcfg)
        |=> alcfg_reg.repeat_count == $past(alcfg_reg.repeat_count) - 8'h01)
        else $error("repeat count not decremented");
    a_rpt_nowrap: assert property (@(posedge pclk) disable iff (!presetn)
        clock_event && rpt_zero && !alcfg_reg.chime && !(wr_go && sel_alcfg)
        |=> alcfg_reg.repeat_count == 8'h00)
        else $error("repeat count wrapped");
    a_mask_flag: assert property (@(posedge pclk) disable iff (!presetn)
        mask_rsv |=> evstat[2]) else $error("reserved mask not flagged");
    a_ptr_step: assert property (@(posedge pclk) disable iff (!presetn)
        alarm_value_access && !(wr_go && sel_alcfg)
        |=> alarm_value_pointer != $past(alarm_value_pointer))
        else $error("pointer did not step");
    a_year_lock: assert property (@(posedge pclk) disable iff (!presetn)
        !unlock_reg |=> $stable(year_reg) && $stable(month_day_value_reg))
        else $error("locked calendar written");
    a_year_read: assert property (@(posedge pclk) disable iff (!presetn)
        sel_year |-> rd_mux[15:8] == 8'h00) else $error("year upper bits");
    a_month_day_value_read: assert property (@(posedge pclk) disable iff (!presetn)
        sel_month_day_value |-> rd_mux[15:13] == 3'h0 && rd_mux[7:6] == 2'h0)
        else $error("month day reserved bits");
    a_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
        clock_event |=> flag_reg) else $error("flag not set");
    a_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        clock_irq |-> ie_reg && flag_reg) else $error("irq not gated");
    default clocking cb_pclk @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_chime_wrap: assert property (
        clock_event && rpt_zero && alcfg_reg.chime && !wr_alcfg
        |=> alcfg_reg.repeat_count == 8'hFF) else $error("no chime wrap");
    a_chime_keep: assert property (
        clock_event && alcfg_reg.chime && !wr_alcfg
        |=> alarm_enable) else $error("chime alarm disabled");
    a_rpt_hold: assert property (
        !clock_event && !wr_alcfg
        |=> $stable(alcfg_reg.repeat_count)) else $error("count moved");
    a_ptr_hold: assert property (
        !alarm_value_access && !wr_alcfg
        |=> $stable(alarm_value_pointer)) else $error("pointer moved");
    a_mask_hold: assert property (
        !wr_alcfg |=> $stable(alarm_interval_mask))
        else $error("mask moved");
    a_cfg_write: assert property (
        wr_alcfg && !clock_event && !alarm_value_access
        |=> alcfg_word == $past(pwdata[15:0])) else $error("cfg write");
    a_year_write: assert property (
        wr_year |=> year_reg == $past(pwdata[7:0]))
        else $error("year write lost");
    a_month_day_value_write: assert property (
        wr_month_day_value |=> month_day_value_reg == $past({pwdata[12:8], pwdata[5:0]}))
        else $error("month day write lost");
    a_flag_hold: assert property (
        flag_reg && !wr_flag |=> flag_reg) else $error("flag dropped");
    a_flag_clear: assert property (
        wr_flag && !pwdata[clar_pkg::IRQ_BIT] && !clock_event
        |=> !flag_reg) else $error("flag not cleared");
    a_ie_write: assert property (
        wr_enab |=> ie_reg == $past(pwdata[clar_pkg::IRQ_BIT]))
        else $error("enable write lost");
    a_irq_off: assert property (
        !ie_reg |-> !clock_irq) else $error("irq while disabled");
    a_unlock_write: assert property (
        wr_ctrl |=> unlock_reg == $past(pwdata[0]))
        else $error("unlock write lost");
    a_even_write: assert property (
        wr_even |=> even_reg == $past(pwdata[2:0]))
        else $error("event enable write lost");
    a_ready_high: assert property (
        psel |-> pready) else $error("ready low");
    a_err_unmapped: assert property (
        psel && penable && !mapped |-> pslverr) else $error("no error");
    a_rdata_upper: assert property (
        prdata[31:16] == 16'h0000) else $error("upper read bits");
    a_rd_capture: assert property (
        rd_setup |=> prdata[15:0] == $past(rd_mux))
        else $error("read data not captured");
    a_rdata_hold: assert property (
        !rd_setup |=> $stable(prdata)) else $error("read data moved");
    a_evclr_clear: assert property (
        wr_evclr && pwdata[0] && !ev_set[0] |=> !evstat[0])
        else $error("event not cleared");
    a_clk_event: assert property (
        clock_event |=> evstat[0]) else $error("clock event lost");
    a_auto_event: assert property (
        clock_event && rpt_zero && !alcfg_reg.chime |=> evstat[1])
        else $error("auto disable event lost");
    a_event_irq: assert property (
        (evstat & even_reg) != 3'h0 |-> irq) else $error("irq missing");

    c_rsv_mask: cover property (@(posedge pclk) disable iff (!presetn)
        mask_rsv);
    c_alarm_off: cover property (@(posedge pclk) disable iff (!presetn)
        clock_event && rpt_zero && !alcfg_reg.chime);
    c_chime_wrap: cover property (@(posedge pclk) disable iff (!presetn)
        clock_event && rpt_zero && alcfg_reg.chime);
    c_year_write: cover property (@(posedge pclk) disable iff (!presetn)
        wr_go && sel_year && unlock_reg);
    c_irq: cover property (@(posedge pclk) disable iff (!presetn) clock_irq);
endmodule // clar_regs
`default_nettype wire

// ==== bench/calendar_alarm_registers_bench.sv ====
// Self-checking bench for the calendar alarm register block
`timescale 1ns/1ps
`default_nettype none
module calendar_alarm_registers_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic alarm_event = 1'b0;
    logic alarm_value_access = 1'b0;
    logic [3:0] alarm_interval_mask;
    logic [1:0] alarm_value_pointer;
    logic alarm_enable;
    logic clock_irq;
    logic irq;
    logic [31:0] rd;
    logic err;
    int mismatches = 0;
    int n_tests = 0;
    always #2 pclk = ~pclk;
    clar_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .alarm_event(alarm_event), .alarm_value_access(alarm_value_access),
        .alarm_interval_mask(alarm_interval_mask),
        .alarm_value_pointer(alarm_value_pointer),
        .alarm_enable(alarm_enable), .clock_irq(clock_irq), .irq(irq));
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Request held until pready is seen at an edge; no wait count assumed
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            stop_test();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Let the access edge land before outputs are looked at
        @(negedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic pulse(input logic ev);
        @(posedge pclk);
        if (ev) alarm_event <= 1'b1;
        else alarm_value_access <= 1'b1;
        @(posedge pclk);
        alarm_event <= 1'b0;
        alarm_value_access <= 1'b0;
        @(negedge pclk);
    endtask
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdc(clar_pkg::OFS_FLAG, 32'h0000_0000);
        rdc(clar_pkg::OFS_ENAB, 32'h0000_0000);
        rdc(clar_pkg::OFS_ALCFG, 32'h0000_0000);
        // Calendar is locked after reset
        wr(clar_pkg::OFS_YEAR, 32'h0000_0099);
        rdc(clar_pkg::OFS_YEAR, 32'h0000_0000);
        apb(1'b0, 12'h040, 32'h0000_0000);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        wr(clar_pkg::OFS_CTRL, 32'h0000_0001);
        wr(clar_pkg::OFS_YEAR, 32'hFFFF_FF59);
        rdc(clar_pkg::OFS_YEAR, 32'h0000_0059);
        wr(clar_pkg::OFS_MONTH_DAY_VALUE, 32'hFFFF_FFFF);
        rdc(clar_pkg::OFS_MONTH_DAY_VALUE, 32'h0000_1F3F);
        wr(clar_pkg::OFS_MONTH_DAY_VALUE, 32'h0000_1231);
        rdc(clar_pkg::OFS_MONTH_DAY_VALUE, 32'h0000_1231);
        // Enabled, no chime, mask 6, pointer 1, two repeats left
        wr(clar_pkg::OFS_ALCFG, 32'h0000_9902);
        chk({28'h0000000, alarm_interval_mask}, 32'h0000_0006);
        pulse(1'b0);
        chk({30'h0000_0000, alarm_value_pointer}, 32'h0000_0000);
        pulse(1'b0);
        chk({30'h0000_0000, alarm_value_pointer}, 32'h0000_0003);
        repeat (3) pulse(1'b1);
        chk({31'h0000_0000, alarm_enable}, 32'h0000_0000);
        rdc(clar_pkg::OFS_ALCFG, 32'h0000_1B00);
        // Chime on: count at zero wraps and alarm stays armed
        wr(clar_pkg::OFS_ALCFG, 32'h0000_C000);
        pulse(1'b1);
        rdc(clar_pkg::OFS_ALCFG, 32'h0000_C0FF);
        rdc(clar_pkg::OFS_FLAG, 32'h0000_4000);
        chk({31'h0000_0000, alarm_enable}, 32'h0000_0001);
        wr(clar_pkg::OFS_FLAG, 32'hFFFF_FFFF);
        rdc(clar_pkg::OFS_FLAG, 32'h0000_4000);
        chk({31'h0000_0000, clock_irq}, 32'h0000_0000);
        wr(clar_pkg::OFS_ENAB, 32'hFFFF_FFFF);
        rdc(clar_pkg::OFS_ENAB, 32'h0000_4000);
        chk({31'h0000_0000, clock_irq}, 32'h0000_0001);
        wr(clar_pkg::OFS_FLAG, 32'h0000_0000);
        chk({31'h0000_0000, clock_irq}, 32'h0000_0000);
        // Reserved interval code raises a maskable event
        wr(clar_pkg::OFS_EVCLR, 32'h0000_0007);
        rdc(clar_pkg::OFS_EVSTAT, 32'h0000_0000);
        wr(clar_pkg::OFS_ALCFG, 32'h0000_2800);
        wr(clar_pkg::OFS_ALCFG, 32'h0000_0000);
        rdc(clar_pkg::OFS_EVSTAT, 32'h0000_0004);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        wr(clar_pkg::OFS_EVEN, 32'h0000_0004);
        chk({31'h0000_0000, irq}, 32'h0000_0001);
        wr(clar_pkg::OFS_EVCLR, 32'h0000_0004);
        rdc(clar_pkg::OFS_EVSTAT, 32'h0000_0000);
        chk({31'h0000_0000, irq}, 32'h0000_0000);
        stop_test();
    end
endmodule // calendar_alarm_registers_bench
`default_nettype wire
